// ### psr_pkg.sv
// psr_pkg: constants for the sleep/reset control block
// assumes: 125 MHz clk, i2c slave inside psr_top
package psr_pkg;
	// ****************************************
	// i2c and registers
	// ****************************************
	localparam logic [6:0] SLAVE_ADDR = 7'h5a;
	localparam logic [7:0] REG_SLEEP_CTRL = 8'h00;
	localparam logic [7:0] REG_MASK = 8'h01;
	localparam logic [7:0] REG_STATUS = 8'h02;
	localparam logic [7:0] REG_MASK_HI = 8'h03;
	localparam logic [7:0] REG_IDENT = 8'h7d;
	localparam int SLEEP_KEEP_BIT = 7;
	// identification value is arbitrary
	localparam logic [7:0] IDENT_CODE = 8'h5c;
	// ****************************************
	// event mask field positions
	// ****************************************
	localparam int EV_MAIN_RST = 0;
	localparam int EV_AUX1 = 1;
	localparam int EV_AUX2 = 2;
	localparam int EV_VIN_OVER = 3;
	localparam int EV_IRQ = 4;
	localparam int EV_IN_OK = 5;
	localparam int EV_THERM = 6;
	localparam int EV_UNDER = 7;
	localparam int EV_OVER = 8;
	localparam int EV_COUNT = 9;
	// 1 = masked; reset pattern per event order above
	localparam logic [8:0] MASK_RESET = 9'h0_037;
	// ****************************************
	// voltage codes
	// ****************************************
	localparam logic [1:0] CONV2_1V50 = 2'h1;
	localparam logic [1:0] CONV2_1V35 = 2'h2;
	localparam logic [1:0] CONV3_1V20 = 2'h1;
	localparam logic [1:0] CONV3_1V80 = 2'h2;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 125;
	localparam int HOLD_US = 1991;
	localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
	typedef enum logic [2:0] {
		PSR_ACTIVE = 3'b001,
		PSR_SLEEP = 3'b010,
		PSR_HOLD = 3'b100
	} psr_state_t;
endpackage : psr_pkg

// ### psr_sync.sv
// psr_sync: three-stage pin synchroniser with agreement filter
// assumes: asynchronous pin, one clock
`timescale 1ns/1ps
module psr_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pin and result
	input wire logic pin,
	output logic level
);
	logic s1;
	logic s2;
	logic s3;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level <= 1'b0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				level <= s3;
			end
		end
	end
endmodule : psr_sync

// ### psr_top.sv
// psr_top: sleep/active control, aux reset one, level selects, masks, i2c slave
// assumes: pins asynchronous to clk; open-drain lines resolved outside
//
// Behaviour
// [RULE1] power enable low means sleep, high active
// [RULE2] aux reset one low on sleep by default
// [RULE3] control bit seven keeps aux reset high
// [RULE4] conv2 level select picks 1.5 or 1.35
// [RULE5] conv2 code follows select pin continuously
// [RULE6] aux reset two pin picks 1.2 or 1.8
// [RULE7] conv3 code follows pin continuously
// [RULE8] out of regulation drives aux reset low
// [RULE9] aux reset released after 1991 us
// [RULE10] nine event sources each have a mask
// [RULE11] register 0x7d returns identification code
// [RULE12] i2c slave at seven-bit address 0x5a
// [RULE13] main reset output not driven
// [RULE14] power good output not driven
// [RULE15] hold counter restarts on renewed fault
// [RULE16] masked events do not reach outputs
`timescale 1ns/1ps
module psr_top
	import psr_pkg::*;
#(
	parameter int HOLD_CYCLES = HOLD_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control pins
	input wire logic power_enable_pin,
	input wire logic conv2_level_select,
	input wire logic aux_reset_two_pin,
	// regulator and event inputs, per EV_* position
	input wire logic [8:0] event_in,
	// reset and status outputs
	output logic aux_reset_one_out,
	output logic main_reset_out_oe,
	output logic power_good_out_oe,
	output logic irq_out,
	output logic sleep_state,
	output logic [1:0] converter_two_code,
	output logic [1:0] converter_three_code,
	// i2c pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe
);
	// ****************************************
	// input synchronisers
	// ****************************************
	logic pen_s, c2_s, c3_s, scl_s, sda_s;
	psr_sync u_pen (.clk(clk), .rst_n(rst_n), .pin(power_enable_pin), .level(pen_s));
	psr_sync u_c2 (.clk(clk), .rst_n(rst_n), .pin(conv2_level_select), .level(c2_s));
	psr_sync u_c3 (.clk(clk), .rst_n(rst_n), .pin(aux_reset_two_pin), .level(c3_s));
	psr_sync u_scl (.clk(clk), .rst_n(rst_n), .pin(scl_in), .level(scl_s));
	psr_sync u_sda (.clk(clk), .rst_n(rst_n), .pin(sda_in), .level(sda_s));

	// ****************************************
	// registers and event gating
	// ****************************************
	logic [7:0] sleep_ctrl;
	logic [8:0] ev_mask;
	logic [8:0] ev_s2;
	logic [8:0] ev_live;
	logic fault;
	// each event pin gets its own four-flop filter
	for (genvar gi = 0; gi < EV_COUNT; gi++) begin : g_ev
		psr_sync u_ev (.clk(clk), .rst_n(rst_n), .pin(event_in[gi]), .level(ev_s2[gi]));
	end
	assign ev_live = ev_s2 & ~ev_mask; // RULE16
	assign fault = ev_live[EV_UNDER] | ev_live[EV_OVER] | ev_live[EV_VIN_OVER]
		| ev_live[EV_THERM] | ev_live[EV_IN_OK]; // RULE8
	assign irq_out = |ev_live; // RULE16

	assign main_reset_out_oe = 1'b0; // RULE13
	assign power_good_out_oe = 1'b0; // RULE14

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			converter_two_code <= CONV2_1V50;
			converter_three_code <= CONV3_1V20;
		end else begin
			converter_two_code <= c2_s ? CONV2_1V35 : CONV2_1V50; // RULE4 RULE5
			converter_three_code <= c3_s ? CONV3_1V80 : CONV3_1V20; // RULE6 RULE7
		end
	end

	// ****************************************
	// sleep / reset state machine
	// ****************************************
	psr_state_t state, next_state;
	logic [17:0] hold_cnt;
	logic keep_high;
	assign keep_high = sleep_ctrl[SLEEP_KEEP_BIT];
	always_comb begin
		next_state = state;
		unique case (state)
			PSR_ACTIVE: begin
				if (!pen_s) next_state = PSR_SLEEP; // RULE1
				else if (fault) next_state = PSR_HOLD; // RULE8
			end
			PSR_SLEEP: begin
				if (pen_s) next_state = PSR_HOLD; // RULE1
			end
			PSR_HOLD: begin
				if (!pen_s) next_state = PSR_SLEEP;
				else if (!fault && hold_cnt == 18'(HOLD_CYCLES - 1)) next_state = PSR_ACTIVE; // RULE9
			end
			default: next_state = PSR_HOLD;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= PSR_HOLD;
			hold_cnt <= '0;
		end else begin
			state <= next_state;
			if (state != PSR_HOLD || fault) hold_cnt <= '0; // RULE15
			else hold_cnt <= hold_cnt + 18'd1;
		end
	end
	assign sleep_state = (state == PSR_SLEEP);
	always_ff @(posedge clk) begin
		if (!rst_n) aux_reset_one_out <= 1'b0;
		else if (state == PSR_ACTIVE && next_state == PSR_ACTIVE) aux_reset_one_out <= 1'b1;
		else if (next_state == PSR_SLEEP && keep_high && !fault)
			aux_reset_one_out <= aux_reset_one_out; // RULE3
		else aux_reset_one_out <= 1'b0; // RULE2 RULE8
	end

	// ****************************************
	// i2c slave
	// ****************************************
	typedef enum logic [4:0] {
		I2C_IDLE = 5'b00001,
		I2C_ADDR = 5'b00010,
		I2C_ACK = 5'b00100,
		I2C_WR = 5'b01000,
		I2C_RD = 5'b10000
	} psr_i2c_t;
	psr_i2c_t i2c_st;
	logic scl_d, sda_d;
	logic [3:0] bitn;
	logic [7:0] shreg, ptr, rd_byte;
	logic have_ptr, ack_drv, is_read;
	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_c = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
	assign rd_byte = (ptr == REG_IDENT) ? IDENT_CODE : // RULE11
		(ptr == REG_SLEEP_CTRL) ? sleep_ctrl :
		(ptr == REG_MASK) ? ev_mask[7:0] :
		(ptr == REG_MASK_HI) ? {7'h00, ev_mask[8]} :
		(ptr == REG_STATUS) ? {5'h00, sleep_state, aux_reset_one_out, fault} : 8'h00;
	assign sda_oe = ack_drv;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_d <= 1'b0; // matches the filters' reset level
			sda_d <= 1'b0;
			i2c_st <= I2C_IDLE;
			bitn <= '0;
			shreg <= '0;
			ptr <= '0;
			is_read <= 1'b0;
			have_ptr <= 1'b0;
			ack_drv <= 1'b0;
			sleep_ctrl <= 8'h00;
			ev_mask <= MASK_RESET;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			if (start_c) begin
				i2c_st <= I2C_ADDR;
				bitn <= '0;
				ack_drv <= 1'b0;
			end else if (stop_c) begin
				i2c_st <= I2C_IDLE;
				ack_drv <= 1'b0;
			end else begin
				unique case (i2c_st)
					I2C_IDLE: ack_drv <= 1'b0;
					I2C_ADDR, I2C_WR: begin
						if (scl_rise) begin
							shreg <= {shreg[6:0], sda_s};
							bitn <= bitn + 4'd1;
						end
						if (scl_fall && bitn == 4'd8) begin
							bitn <= '0;
							if (i2c_st == I2C_ADDR) begin
								if (shreg[7:1] == SLAVE_ADDR) begin // RULE12
									ack_drv <= 1'b1;
									is_read <= shreg[0];
									have_ptr <= 1'b0;
									i2c_st <= I2C_ACK;
								end else i2c_st <= I2C_IDLE;
							end else begin
								ack_drv <= 1'b1;
								i2c_st <= I2C_ACK;
								if (!have_ptr) begin
									ptr <= shreg;
									have_ptr <= 1'b1;
								end else begin
									if (ptr == REG_SLEEP_CTRL) sleep_ctrl <= shreg; // RULE3
									if (ptr == REG_MASK) ev_mask[7:0] <= shreg; // RULE10
									if (ptr == REG_MASK_HI) ev_mask[8] <= shreg[0]; // RULE10
									ptr <= ptr + 8'd1;
								end
							end
						end
					end
					I2C_ACK: begin
						if (scl_fall) begin
							if (is_read) begin
								i2c_st <= I2C_RD;
								shreg <= rd_byte;
								ack_drv <= ~rd_byte[7];
								ptr <= ptr + 8'd1;
							end else begin
								i2c_st <= I2C_WR;
								ack_drv <= 1'b0;
							end
						end
					end
					I2C_RD: begin
						if (scl_fall) begin
							bitn <= bitn + 4'd1;
							if (bitn == 4'd7) begin
								ack_drv <= 1'b0;
							end else if (bitn == 4'd8) begin
								bitn <= '0;
								if (sda_d) i2c_st <= I2C_IDLE;
								else begin
									shreg <= rd_byte;
									ack_drv <= ~rd_byte[7];
									ptr <= ptr + 8'd1;
								end
							end else begin
								shreg <= {shreg[6:0], 1'b0};
								ack_drv <= ~shreg[6];
							end
						end
					end
					default: i2c_st <= I2C_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	property p_sleep_low;
		@(posedge clk) disable iff (!rst_n)
		(state == PSR_SLEEP && !keep_high) |=> !aux_reset_one_out;
	endproperty
	a_sleep_low: assert property (p_sleep_low) else $error("aux reset high in sleep"); // RULE2
	property p_fault_low;
		@(posedge clk) disable iff (!rst_n) fault |=> !aux_reset_one_out;
	endproperty
	a_fault_low: assert property (p_fault_low) else $error("aux reset high on fault"); // RULE8
	property p_pen_sleep;
		@(posedge clk) disable iff (!rst_n) !pen_s |=> sleep_state;
	endproperty
	a_pen_sleep: assert property (p_pen_sleep) else $error("not asleep"); // RULE1
	property p_conv2;
		@(posedge clk) disable iff (!rst_n)
		c2_s |=> converter_two_code == CONV2_1V35;
	endproperty
	a_conv2: assert property (p_conv2) else $error("conv2 code wrong"); // RULE5
	property p_conv3;
		@(posedge clk) disable iff (!rst_n)
		!c3_s |=> converter_three_code == CONV3_1V20;
	endproperty
	a_conv3: assert property (p_conv3) else $error("conv3 code wrong"); // RULE7
	property p_restart;
		@(posedge clk) disable iff (!rst_n) fault |=> hold_cnt == 18'd0;
	endproperty
	a_restart: assert property (p_restart) else $error("hold not restarted"); // RULE15
	property p_mask;
		@(posedge clk) disable iff (!rst_n) (ev_s2 & ~ev_mask) == 9'h0_000 |-> !irq_out;
	endproperty
	a_mask: assert property (p_mask) else $error("masked event seen"); // RULE16
	property p_nodrive;
		@(posedge clk) !main_reset_out_oe && !power_good_out_oe;
	endproperty
	a_nodrive: assert property (p_nodrive) else $error("dead pin driven"); // RULE13
	property p_rise;
		@(posedge clk) disable iff (!rst_n)
		$rose(aux_reset_one_out) |-> $past(state) == PSR_ACTIVE;
	endproperty
	a_rise: assert property (p_rise) else $error("early release"); // RULE9
	c_sleep: cover property (@(posedge clk) state == PSR_SLEEP);
	c_release: cover property (@(posedge clk) $rose(aux_reset_one_out));
	c_ack: cover property (@(posedge clk) i2c_st == I2C_ACK);
	c_keep: cover property (@(posedge clk) sleep_state && aux_reset_one_out);
endmodule : psr_top

// ### psr_host.sv
// psr_host: host-side i2c master driving the block's slave port
// assumes: shares clk with the block; sda has a pull-up
`timescale 1ns/1ps
module psr_host (
	// clock
	input wire logic clk,
	// i2c wire
	input wire logic sda_oe,
	output logic scl_in,
	output logic sda_in
);
	logic host_low = 1'b0;
	logic scl = 1'b1;
	// released line reads high through the pull-up
	assign sda_in = ~(sda_oe | host_low);
	assign scl_in = scl;
	task automatic phase();
		repeat (8) @(posedge clk);
	endtask : phase
	task automatic start();
		host_low <= 1'b0;
		phase();
		scl <= 1'b1;
		phase();
		host_low <= 1'b1;
		phase();
		scl <= 1'b0;
		phase();
	endtask : start
	task automatic stop();
		host_low <= 1'b1;
		phase();
		scl <= 1'b1;
		phase();
		host_low <= 1'b0;
		phase();
	endtask : stop
	// data set before, held after the high phase
	task automatic clock_bit(output logic b);
		phase();
		scl <= 1'b1;
		phase();
		b = sda_in;
		scl <= 1'b0;
		phase();
	endtask : clock_bit
	task automatic send(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			host_low <= ~d[i];
			clock_bit(b);
		end
		host_low <= 1'b0;
		clock_bit(b);
		ack = ~b;
	endtask : send
	task automatic recv(output logic [7:0] d);
		logic b;
		host_low <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(b);
			d[i] = b;
		end
		clock_bit(b);
	endtask : recv
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic k0, k1, k2;
		start();
		send(8'hb4, k0);
		send(a, k1);
		send(d, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic k0, k1, k2;
		start();
		send(8'hb4, k0);
		send(a, k1);
		start();
		send(8'hb5, k2);
		recv(d);
		stop();
		ok = k0 & k1 & k2;
	endtask : reg_read
endmodule : psr_host

// ### tb_pmic_sleep_reset_control.sv
// tb_pmic_sleep_reset_control: self-checking bench for psr_top
// assumes: psr_pkg, psr_top and psr_host compiled first
`timescale 1ns/1ps
module tb_pmic_sleep_reset_control;
	import psr_pkg::*;
	localparam int HOLD = 50;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic power_enable_pin = 1'b0;
	logic conv2_level_select = 1'b0;
	logic aux_reset_two_pin = 1'b0;
	logic [8:0] event_in = 9'h0_000;
	logic aux_reset_one_out, main_reset_out_oe, power_good_out_oe, irq_out, sleep_state;
	logic [1:0] converter_two_code, converter_three_code;
	logic scl_in, sda_in, sda_oe, ok;
	logic [7:0] d;
	int failures = 0;
	int check_count = 0;
	int cycles = 0;
	always #4 clk = ~clk;
	psr_top #(.HOLD_CYCLES(HOLD)) dut_u (.clk(clk), .rst_n(rst_n),
		.power_enable_pin(power_enable_pin), .conv2_level_select(conv2_level_select),
		.aux_reset_two_pin(aux_reset_two_pin), .event_in(event_in),
		.aux_reset_one_out(aux_reset_one_out), .main_reset_out_oe(main_reset_out_oe),
		.power_good_out_oe(power_good_out_oe), .irq_out(irq_out), .sleep_state(sleep_state),
		.converter_two_code(converter_two_code), .converter_three_code(converter_three_code),
		.scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe));
	psr_host host_u (.clk(clk), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));
	// ****************************************
	// helpers
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_ident();
		host_u.reg_read(REG_IDENT, d, ok);
		chk("ident ack", 8'h01, {7'h00, ok});
		chk("ident", IDENT_CODE, d);
		host_u.start();
		host_u.send(8'hb6, ok);
		host_u.stop();
		chk("foreign addr ack", 8'h00, {7'h00, ok});
		chk("main reset oe", 8'h00, {7'h00, main_reset_out_oe});
		chk("power good oe", 8'h00, {7'h00, power_good_out_oe});
	endtask : t_ident
	task automatic t_levels();
		for (int i = 0; i < 4; i++) begin
			conv2_level_select <= i[0];
			aux_reset_two_pin <= i[1];
			tick(8);
			chk("conv2 code", {6'h00, i[0] ? CONV2_1V35 : CONV2_1V50}, converter_two_code);
			chk("conv3 code", {6'h00, i[1] ? CONV3_1V80 : CONV3_1V20}, converter_three_code);
		end
	endtask : t_levels
	task automatic t_hold();
		int n;
		power_enable_pin <= 1'b1;
		tick(30);
		chk("aux in hold", 8'h00, {7'h00, aux_reset_one_out});
		event_in[EV_UNDER] <= 1'b1;
		tick(8);
		chk("aux on fault", 8'h00, {7'h00, aux_reset_one_out});
		chk("irq on fault", 8'h01, {7'h00, irq_out});
		event_in[EV_UNDER] <= 1'b0;
		n = 0;
		while (aux_reset_one_out !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		chk("hold length ok", 8'h01, {7'h00, n >= HOLD && n <= HOLD + 8});
	endtask : t_hold
	task automatic t_mask();
		event_in[EV_MAIN_RST] <= 1'b1;
		tick(8);
		chk("masked irq", 8'h00, {7'h00, irq_out});
		host_u.reg_write(REG_MASK, 8'h36, ok);
		chk("unmasked irq", 8'h01, {7'h00, irq_out & ok});
		event_in[EV_MAIN_RST] <= 1'b0;
		host_u.reg_read(REG_MASK, d, ok);
		chk("mask readback", 8'h36, d);
		host_u.reg_write(REG_MASK_HI, 8'h01, ok);
		event_in[EV_OVER] <= 1'b1;
		tick(8);
		chk("masked over irq", 8'h00, {7'h00, irq_out});
		chk("masked over aux", 8'h01, {7'h00, aux_reset_one_out});
		event_in[EV_OVER] <= 1'b0;
		host_u.reg_write(REG_MASK_HI, 8'h00, ok);
		host_u.reg_write(REG_MASK, 8'h37, ok);
	endtask : t_mask
	task automatic t_sleep();
		power_enable_pin <= 1'b0;
		tick(8);
		chk("sleep", 8'h01, {7'h00, sleep_state});
		chk("aux in sleep", 8'h00, {7'h00, aux_reset_one_out});
		power_enable_pin <= 1'b1;
		tick(HOLD + 20);
		chk("active", 8'h02, {6'h00, aux_reset_one_out, sleep_state});
		host_u.reg_write(REG_SLEEP_CTRL, 8'h80, ok);
		power_enable_pin <= 1'b0;
		tick(8);
		chk("keep aux in sleep", 8'h03, {6'h00, aux_reset_one_out, sleep_state});
		power_enable_pin <= 1'b1;
		tick(8);
	endtask : t_sleep
	initial begin
		tick(6);
		rst_n <= 1'b1;
		tick(2);
		t_ident();
		t_levels();
		t_hold();
		t_mask();
		t_sleep();
		wrap_up();
	end
endmodule : tb_pmic_sleep_reset_control
